// >>> design/fpcs_clock_synth.sv
/*
  digital model of a fractional-N clock synthesiser: selects reference and
  feedback sources, generates a synthesised tick stream with a fractional
  accumulator, four output dividers with cascade, phase offsets and lock.
  assumes the reference and feedback pins are slow against core_clk_in and
  are sampled as levels; configuration inputs come from the same clock domain.
*/
// What this block does
// - reference from pin or internal routing
// - feedback from routing or pin
// - feedback divider multiplies reference frequency
// - sixteen-bit fractional multiplication setting supported
// - each output divider independently one to 128
// - output dividers may be chained in cascade
// - each output to clock network or routing
// - lock raised when locked, dropped on loss
// - secondaries phase shifted against primary output
`timescale 1ns/100ps
`default_nettype none
module fpcs_clock_synth #(
  parameter int FBDIV_W = fpcs_pkg::FBDIV_W,
  parameter int FRAC_W  = fpcs_pkg::FRAC_W
) (
  // clock, reset, enable
  input  wire logic                             core_clk_in,
  input  wire logic                             sys_rst_in,
  input  wire logic                             clk_en_in,
  // reference and feedback sources
  input  wire logic                             ref_clk_in,
  input  wire logic                             ref_route_in,
  input  wire logic                             ref_sel_route_in,
  input  wire logic                             feedback_clk_in,
  input  wire logic                             feedback_route_in,
  input  wire logic                             fb_sel_pin_in,
  // synthesis setting
  input  wire logic [FBDIV_W-1:0]               fb_mult_in,
  input  wire logic [FRAC_W-1:0]                fb_frac_in,
  // output dividers, value 0 means 128
  input  wire logic [4*fpcs_pkg::ODIV_W-1:0]    out_div_in,
  input  wire logic [3:0]                       cascade_in,
  input  wire logic [3*fpcs_pkg::PHASE_W-1:0]   phase_in,
  input  wire logic [3:0]                       net_sel_in,
  // outputs
  output logic                                  primary_clk_out,
  output logic                                  secondary_clk_out_a,
  output logic                                  secondary_clk_out_b,
  output logic                                  secondary_clk_out_c,
  output logic [3:0]                            net_clk_out,
  output logic [3:0]                            route_clk_out,
  output logic                                  synth_clk_out,
  output logic                                  lock_out
);
  localparam int OW = fpcs_pkg::ODIV_W;
  localparam int PW = fpcs_pkg::PHASE_W;

  // ==========================================================
  // input synchronisers
  logic [3:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt, ref_prev_r, ref_prev_nxt;
  logic       ref_lvl, fb_lvl, ref_edge, fb_edge;
  always_comb begin
    sync1_nxt = {feedback_route_in, feedback_clk_in, ref_route_in, ref_clk_in};
    sync2_nxt = sync1_r;
    ref_lvl   = ref_sel_route_in ? sync2_r[1] : sync2_r[0];
    fb_lvl    = fb_sel_pin_in ? sync2_r[2] : sync2_r[3];
    ref_prev_nxt = {2'b00, fb_lvl, ref_lvl};
    ref_edge  = ref_lvl & ~ref_prev_r[0];
    fb_edge   = fb_lvl & ~ref_prev_r[1];
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sync1_r    <= 4'h0;
      sync2_r    <= 4'h0;
      ref_prev_r <= 4'h0;
    end else if (clk_en_in) begin
      sync1_r    <= sync1_nxt;
      sync2_r    <= sync2_nxt;
      ref_prev_r <= ref_prev_nxt;
    end
  end

  // ==========================================================
  // synthesiser: per reference period, emit mult.frac ticks spread evenly
  // ticks are core-clock pulses; a real loop would slew, this model jumps
  localparam int AW = 16 + FRAC_W;
  logic [15:0]       per_cnt_r, per_cnt_nxt, per_len_r, per_len_nxt;
  logic [AW-1:0]     phase_acc_r, phase_acc_nxt, phase_lim;
  logic              tick;
  logic [FBDIV_W+FRAC_W:0] step;
  always_comb begin
    per_cnt_nxt   = per_cnt_r + 16'h0001;
    per_len_nxt   = per_len_r;
    phase_acc_nxt = phase_acc_r;
    tick          = 1'b0;
    step          = {1'b0, fb_mult_in, fb_frac_in};
    phase_lim     = {per_len_r, {FRAC_W{1'b0}}};
    if (ref_edge) begin
      per_len_nxt = per_cnt_r;
      per_cnt_nxt = 16'h0001;
    end
    if (per_len_r != 16'h0000) begin
      // step is mult.frac ticks per period, the limit one whole period
      phase_acc_nxt = phase_acc_r + AW'(step);
      if (phase_acc_nxt >= phase_lim) begin
        phase_acc_nxt = phase_acc_nxt - phase_lim;
        tick = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      per_cnt_r   <= 16'h0000;
      per_len_r   <= 16'h0000;
      phase_acc_r <= '0;
    end else if (clk_en_in) begin
      per_cnt_r   <= per_cnt_nxt;
      per_len_r   <= per_len_nxt;
      phase_acc_r <= phase_acc_nxt;
    end
  end

  // ==========================================================
  // output dividers with cascade and phase offset
  logic [3:0]    div_tick;
  logic [3:0]    div_q;
  logic [3:0]    src_tick;
  genvar g;
  generate
    for (g = 0; g < fpcs_pkg::NUM_OUT; g++) begin : g_div
      logic [OW:0]   cnt_r, cnt_nxt, limit;
      logic          q_r, q_nxt;
      logic          aligned_r, aligned_nxt;
      logic [PW-1:0] ph;
      always_comb begin
        // cascade takes the previous divider's terminal tick
        src_tick[g] = (g > 0 && cascade_in[g]) ? div_tick[(g+3)%4] : tick;
        limit = (out_div_in[g*OW +: OW] == '0) ? (OW+1)'(fpcs_pkg::ODIV_MAX)
                                                : {1'b0, out_div_in[g*OW +: OW]};
        ph = (g == 0) ? '0 : phase_in[(g-1)*PW +: PW];
        cnt_nxt = cnt_r;
        // divide by one gives a one-cycle pulse per source tick
        q_nxt   = (limit == (OW+1)'(1)) ? 1'b0 : q_r;
        aligned_nxt = aligned_r;
        div_tick[g] = 1'b0;
        if (src_tick[g]) begin
          if (cnt_r + 1'b1 >= limit) begin
            cnt_nxt = '0;
            div_tick[g] = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
          q_nxt = (cnt_nxt < (limit >> 1)) | (limit == (OW+1)'(1));
        end
        // phase preloads once, at the primary's first terminal tick; doing it
        // on every primary tick would stall any slower secondary
        if (g != 0 && div_tick[0] && !aligned_r) begin
          cnt_nxt     = (OW+1)'(ph) % limit;
          aligned_nxt = 1'b1;
        end
      end
      always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
          cnt_r     <= '0;
          q_r       <= 1'b0;
          aligned_r <= 1'b0;
        end else if (clk_en_in) begin
          cnt_r     <= cnt_nxt;
          q_r       <= q_nxt;
          aligned_r <= aligned_nxt;
        end
      end
      assign div_q[g] = q_r;
      assign net_clk_out[g]   = net_sel_in[g] ? 1'b0 : q_r;
      assign route_clk_out[g] = net_sel_in[g] ? q_r : 1'b0;
    end
  endgenerate
  assign primary_clk_out     = div_q[0];
  assign secondary_clk_out_a = div_q[1];
  assign secondary_clk_out_b = div_q[2];
  assign secondary_clk_out_c = div_q[3];
  assign synth_clk_out       = tick;

  // ==========================================================
  // lock: compare feedback edges against expected per reference period
  logic [15:0] fb_cnt_r, fb_cnt_nxt;
  logic [3:0]  good_r, good_nxt;
  logic        lock_r, lock_nxt;
  logic [15:0] diff;
  always_comb begin
    fb_cnt_nxt = fb_cnt_r + (fb_edge ? 16'h0001 : 16'h0000);
    good_nxt   = good_r;
    lock_nxt   = lock_r;
    diff       = 16'h0000;
    if (ref_edge) begin
      diff = (fb_cnt_r > 16'(fb_mult_in)) ? fb_cnt_r - 16'(fb_mult_in)
                                          : 16'(fb_mult_in) - fb_cnt_r;
      fb_cnt_nxt = 16'h0000;
      if (diff <= 16'(fpcs_pkg::LOCK_TOL)) begin
        if (good_r != 4'(fpcs_pkg::LOCK_GOOD_CNT))
          good_nxt = good_r + 4'h1;
        else
          lock_nxt = 1'b1;
      end else begin
        good_nxt = 4'h0;
        lock_nxt = 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      fb_cnt_r <= 16'h0000;
      good_r   <= 4'h0;
      lock_r   <= 1'b0;
    end else if (clk_en_in) begin
      fb_cnt_r <= fb_cnt_nxt;
      good_r   <= good_nxt;
      lock_r   <= lock_nxt;
    end
  end
  assign lock_out = lock_r;
endmodule // fpcs_clock_synth
`default_nettype wire

// >>> design/fpcs_pkg.sv
/*
  constants for the fractional clock synthesiser: divider ranges, phase
  field widths, lock qualification counts.
  assumes a single 25 MHz system clock drives the digital model.
*/
package fpcs_pkg;
  localparam int FRAC_W        = 16;
  localparam int FBDIV_W       = 8;
  localparam int ODIV_W        = 7;
  localparam int ODIV_MIN      = 1;
  localparam int ODIV_MAX      = 128;
  localparam int PHASE_W       = 8;
  localparam int NUM_OUT       = 4;
  localparam int LOCK_WIN_CYC  = 16;
  localparam int LOCK_TOL      = 2;
  localparam int LOCK_GOOD_CNT = 4;
  typedef enum logic [1:0] {FPCS_SRC_PIN, FPCS_SRC_ROUTE} fpcs_src_t;
endpackage

// >>> sim/fpcs_far_side.sv
/* far-side clock sources: reference period 64 cycles, feedback four times faster.
   assumes the bench clock; the unselected line toggles every cycle as noise */
`timescale 1ns/100ps
`default_nettype none
// ==========
// partner
module fpcs_far_side (
  input  wire logic clk_in, ref_route_sel_in, fb_pin_sel_in, fb_run_in,
  output logic      ref_pin_out, ref_route_out, fb_pin_out, fb_route_out
);
  int   n = 0;
  logic r = 1'b0, f = 1'b0, junk = 1'b0;
  always @(posedge clk_in) begin
    #1;
    n = (n + 1) % 64;
    r = n < 32;
    if (fb_run_in) f = n[3]; // stopped feedback stands still
    junk = ~junk;
  end
  assign ref_pin_out   = ref_route_sel_in ? junk : r;
  assign ref_route_out = ref_route_sel_in ? r : junk;
  assign fb_pin_out    = fb_pin_sel_in ? f : junk;
  assign fb_route_out  = fb_pin_sel_in ? junk : f;
endmodule // fpcs_far_side
`default_nettype wire

// >>> sim/fpcs_monitor.sv
/* port assertions for fpcs_clock_synth; bound below to every instance */
`timescale 1ns/100ps
`default_nettype none
// ==========
// checker
module fpcs_monitor (
  input wire logic       core_clk_in, sys_rst_in, clk_en_in, feedback_clk_in, feedback_route_in, fb_sel_pin_in,
  input wire logic       primary_clk_out, secondary_clk_out_a, secondary_clk_out_b, secondary_clk_out_c, lock_out,
  input wire logic [3:0] net_sel_in, net_clk_out, route_clk_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] idle_r, idle_nxt, age_r, age_nxt;
  logic       fb_r;
  wire logic       fb   = fb_sel_pin_in ? feedback_clk_in : feedback_route_in;
  wire logic [3:0] outs = {secondary_clk_out_c, secondary_clk_out_b, secondary_clk_out_a, primary_clk_out};
  // both counters saturate so a long run never wraps into a false pass
  always_comb begin
    idle_nxt = (sys_rst_in || fb != fb_r) ? 8'h00 : idle_r + {7'h00, idle_r != 8'hff};
    age_nxt  = sys_rst_in ? 8'h00 : age_r + {7'h00, age_r != 8'hff};
  end
  always_ff @(posedge core_clk_in) begin
    fb_r   <= fb;
    idle_r <= idle_nxt;
    age_r  <= age_nxt;
  end
  sequence s_fb_dead; idle_r >= 8'd200; endsequence
  property p_rst; disable iff (1'b0) sys_rst_in |=> !lock_out && outs == 4'h0; endproperty
  property p_net; net_clk_out == (outs & ~net_sel_in); endproperty
  property p_route; route_clk_out == (outs & net_sel_in); endproperty
  property p_early; $rose(lock_out) |-> age_r >= 8'd20; endproperty
  property p_frozen; !clk_en_in |=> $stable(lock_out) && $stable(outs); endproperty
  property p_drop; s_fb_dead |-> !lock_out; endproperty
  property p_need_fb; $rose(lock_out) |-> idle_r < 8'd100; endproperty
  property p_keep; $fell(lock_out) |-> idle_r >= 8'd16; endproperty
  a_rst: assert property (p_rst) else $error("lock or output high after reset");
  a_net: assert property (p_net) else $error("network copy wrong");
  a_route: assert property (p_route) else $error("routing copy wrong");
  a_early: assert property (p_early) else $error("lock too soon after reset");
  a_frozen: assert property (p_frozen) else $error("state moved while disabled");
  a_drop: assert property (p_drop) else $error("lock held without feedback");
  a_need_fb: assert property (p_need_fb) else $error("lock without live feedback");
  a_keep: assert property (p_keep) else $error("lock lost with live feedback");
endmodule // fpcs_monitor
bind fpcs_clock_synth fpcs_monitor fpcs_monitor_inst (.core_clk_in, .sys_rst_in, .clk_en_in, .feedback_clk_in,
  .feedback_route_in, .fb_sel_pin_in, .primary_clk_out, .secondary_clk_out_a, .secondary_clk_out_b,
  .secondary_clk_out_c, .lock_out, .net_sel_in, .net_clk_out, .route_clk_out);
`default_nettype wire

// >>> sim/tb_fractional_pll_clock_synth.sv
/* self-checking bench; the partner makes the clock sources, the bench the setup */
`timescale 1ns/100ps
`default_nettype none
// ==========
// bench
module tb_fractional_pll_clock_synth;
  logic       core_clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1, rsel = 1'b0, fsel = 1'b1, run = 1'b1;
  logic [3:0] nsel = 4'h5, net_o, rt_o;
  logic       rp, rr, fp, fr, p, sa, sb, sc, syn, lock;
  int         error_cnt = 0, compares = 0;
  always #20 core_clk_in = ~core_clk_in;
  fpcs_far_side fpcs_far_side_inst (.clk_in(core_clk_in), .ref_route_sel_in(rsel), .fb_pin_sel_in(fsel),
    .fb_run_in(run), .ref_pin_out(rp), .ref_route_out(rr), .fb_pin_out(fp), .fb_route_out(fr));
  fpcs_clock_synth fpcs_clock_synth_inst (.core_clk_in, .sys_rst_in, .clk_en_in, .ref_clk_in(rp),
    .ref_route_in(rr), .ref_sel_route_in(rsel), .feedback_clk_in(fp), .feedback_route_in(fr),
    .fb_sel_pin_in(fsel), .fb_mult_in(8'h04), .fb_frac_in(16'h0000), .out_div_in({7'h02, 7'h03, 7'h02, 7'h01}),
    .cascade_in(4'h8), .phase_in(24'h100804), .net_sel_in(nsel), .primary_clk_out(p),
    .secondary_clk_out_a(sa), .secondary_clk_out_b(sb), .secondary_clk_out_c(sc), .net_clk_out(net_o),
    .route_clk_out(rt_o), .synth_clk_out(syn), .lock_out(lock));
  task automatic check(input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t lock or output exp %b got %b", $time, exp, got);
    end
  endtask
  task automatic check_cnt(input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[ERR] %0t edge count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // four reference periods of 64 cycles at multiply 4 give 16 synth ticks
  task automatic t_divide;
    int   n_syn = 0, n_p = 0, n_a = 0, n_b = 0, n_c = 0;
    logic q_p = p, q_a = sa, q_b = sb, q_c = sc;
    for (int i = 0; i < 256; i++) begin
      @(posedge core_clk_in);
      #1;
      n_syn += int'(syn === 1'b1);
      n_p   += int'(p === 1'b1 && q_p === 1'b0);
      n_a   += int'(sa === 1'b1 && q_a === 1'b0);
      n_b   += int'(sb === 1'b1 && q_b === 1'b0);
      n_c   += int'(sc === 1'b1 && q_c === 1'b0);
      q_p = p;
      q_a = sa;
      q_b = sb;
      q_c = sc;
    end
    check_cnt(16, 16, n_syn);
    check_cnt(16, 16, n_p);
    check_cnt(8, 8, n_a);
    check_cnt(5, 6, n_b);
    check_cnt(1, 4, n_c);
    $display("t_divide done");
  endtask
  task automatic wait_lock(input logic v);
    for (int i = 0; i < 1000 && lock !== v; i++) begin
      @(posedge core_clk_in);
      #1;
    end
  endtask
  task automatic t_reset;
    check(1'b0, lock);
    check(1'b0, p);
    clk_en_in = 1'b0;
    repeat (10) @(posedge core_clk_in);
    #1 clk_en_in = 1'b1;
    $display("t_reset done");
  endtask
  task automatic t_lock;
    wait_lock(1'b1);
    check(1'b1, lock);
    nsel = ~nsel; // steering flips while outputs run
    $display("t_lock done");
  endtask
  task automatic t_loss;
    run = 1'b0;
    wait_lock(1'b0);
    check(1'b0, lock);
    run = 1'b1;
    wait_lock(1'b1);
    check(1'b1, lock);
    $display("t_loss done");
  endtask
  task automatic t_route;
    sys_rst_in = 1'b1;
    rsel = 1'b1;
    fsel = 1'b0;
    repeat (6) @(posedge core_clk_in);
    #1 check(1'b0, lock);
    sys_rst_in = 1'b0;
    wait_lock(1'b1);
    check(1'b1, lock);
    $display("t_route done");
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    #1 sys_rst_in = 1'b0;
    t_reset();
    t_lock();
    t_divide();
    t_loss();
    t_route();
    stop_test();
  end
  initial begin
    #(40 * 8000);
    error_cnt++;
    stop_test();
  end
endmodule // tb_fractional_pll_clock_synth
`default_nettype wire
